// ==== hw/sbdac_regs.sv ====
// AXI4-Lite register block of the stereo bitstream DAC: sample holding,
// control, interrupt mask and sticky status, plus the converter pacing.
// Assumes one 200 MHz clock; the converter rate is a divided enable.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps

module sbdac_regs
    import sbdac_pkg::*;
(
    input wire logic clk, // 200 MHz clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic [15:0] chan_lo_sample, // First channel sample to modulator
    output logic [15:0] chan_hi_sample, // Second channel sample to modulator
    output logic conv_enable, // Converter datapath enable
    output logic sample_strobe, // One pulse per consumed sample pair
    output logic dma_req, // Request for next sample pair
    output logic irq // Interrupt line, active high
);

    import sbdac_pkg::*;

    // ----------------------------------------------------------------
    // State record
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic aw_have; // Write address captured
        logic [7:0] aw_addr; // Captured write address
        logic w_have; // Write data captured
        logic [31:0] w_data; // Captured write data
        logic [3:0] w_strb; // Captured strobes
        logic awready; // Bus ready flops
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] sample; // Holding register, already swapped
        logic pend; // Holding register awaits consumption
        logic en; // Converter enable
        logic swap; // Channel swap
        logic msk_rdy; // Ready interrupt enabled
        logic msk_und; // Underrun interrupt enabled
        logic st_rdy; // Sticky ready flag
        logic st_und; // Sticky underrun flag
        sbdac_cv_t cv; // Converter sequencing state
        logic [7:0] div_cnt; // System cycles within a converter tick
        logic [7:0] tick_cnt; // Converter ticks within a sample period
        logic [15:0] chan_lo; // Samples presented to the modulator
        logic [15:0] chan_hi;
        logic strobe; // Sample consumed pulse
        logic dma; // DMA request level
        logic irq; // Interrupt level
    } sbdac_state_t;

    sbdac_state_t st_r;
    sbdac_state_t st_nxt;

    // Decode helpers
    logic wr_go; // Write performed this cycle
    logic rd_go; // Read address taken this cycle
    logic conv_tick; // One converter clock cycle elapses
    logic sample_tick; // End of a 256-tick sample period
    logic rdy_evt; // Converter can take a new pair
    logic und_evt; // Period ended with no new pair
    logic [31:0] wmask; // Byte strobes widened to bits
    logic [31:0] wval; // Write data after strobes
    logic [31:0] rd_val; // Value selected for a read
    logic rd_ok; // Read address is inside the map
    logic wr_ok; // Write address is inside the map

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Bus handshakes, converter pacing, flags
    always_comb
    begin
        st_nxt = st_r;
        wr_go = st_r.aw_have && st_r.w_have && !st_r.bvalid;
        rd_go = s_axi_arvalid && st_r.arready;
        wmask = {{8{st_r.w_strb[3]}}, {8{st_r.w_strb[2]}},
                 {8{st_r.w_strb[1]}}, {8{st_r.w_strb[0]}}};
        wval = st_r.w_data & wmask;
        wr_ok = (st_r.aw_addr[1:0] == 2'h0) && (st_r.aw_addr <= SBDAC_OFS_LAST);
        rd_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= SBDAC_OFS_LAST);
        conv_tick = 1'b0;
        sample_tick = 1'b0;
        rdy_evt = 1'b0;
        und_evt = 1'b0;
        st_nxt.strobe = 1'b0;

        // Write address and data channels, taken in either order
        if (s_axi_awvalid && st_r.awready)
        begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready)
        begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end

        // Write response handshake
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end

        // Read data handshake
        if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end

        // Converter pacing; only runs while enabled
        case (st_r.cv)
            SBDAC_CV_IDLE:
            begin
                st_nxt.div_cnt = 8'h00;
                st_nxt.tick_cnt = 8'h00;
                if (st_r.en)
                begin
                    // Holding register may already be full; ask only if empty
                    st_nxt.cv = SBDAC_CV_RUN;
                    rdy_evt = !st_r.pend;
                end
            end
            SBDAC_CV_RUN:
            begin
                conv_tick = (st_r.div_cnt == SBDAC_CONV_DIV - 8'h01);
                sample_tick = conv_tick && (st_r.tick_cnt == SBDAC_TICKS_LAST);
                st_nxt.div_cnt = conv_tick ? 8'h00 : st_r.div_cnt + 8'h01;
                if (conv_tick)
                begin
                    st_nxt.tick_cnt = st_r.tick_cnt + 8'h01;
                end
                if (sample_tick)
                begin
                    if (st_r.pend)
                    begin
                        // Move the pair to the modulator and ask for the next
                        st_nxt.chan_lo = st_r.sample[15:0];
                        st_nxt.chan_hi = st_r.sample[31:16];
                        st_nxt.pend = 1'b0;
                        st_nxt.strobe = 1'b1;
                        rdy_evt = 1'b1;
                    end
                    else
                    begin
                        // Old pair is replayed; software was too late
                        und_evt = 1'b1;
                    end
                end
                if (!st_r.en)
                begin
                    st_nxt.cv = SBDAC_CV_IDLE;
                end
            end
            default:
            begin
                st_nxt.cv = SBDAC_CV_IDLE;
            end
        endcase

        // Register writes; unmapped words and reserved bits are dropped
        if (wr_go)
        begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_ok ? SBDAC_RESP_OKAY : SBDAC_RESP_SLVERR;
            if (wr_ok)
            begin
                case (st_r.aw_addr)
                    SBDAC_OFS_SAMPLE:
                    begin
                        // A write in the consume cycle wins and stays pending
                        if (st_r.swap)
                        begin
                            st_nxt.sample = ({wval[15:0], wval[31:16]} &
                                {wmask[15:0], wmask[31:16]}) |
                                (st_r.sample & ~{wmask[15:0], wmask[31:16]});
                        end
                        else
                        begin
                            st_nxt.sample = wval | (st_r.sample & ~wmask);
                        end
                        st_nxt.pend = |st_r.w_strb;
                    end
                    SBDAC_OFS_CONTROL:
                    begin
                        if (st_r.w_strb[3])
                        begin
                            st_nxt.en = wval[SBDAC_BIT_EN];
                            st_nxt.swap = wval[SBDAC_BIT_SWAP];
                        end
                    end
                    SBDAC_OFS_IEN:
                    begin
                        st_nxt.msk_rdy = st_r.msk_rdy | wval[SBDAC_BIT_RDY];
                        st_nxt.msk_und = st_r.msk_und | wval[SBDAC_BIT_UND];
                    end
                    SBDAC_OFS_IDIS:
                    begin
                        st_nxt.msk_rdy = st_r.msk_rdy & ~wval[SBDAC_BIT_RDY];
                        st_nxt.msk_und = st_r.msk_und & ~wval[SBDAC_BIT_UND];
                    end
                    SBDAC_OFS_ICLR:
                    begin
                        st_nxt.st_rdy = st_r.st_rdy & ~wval[SBDAC_BIT_RDY];
                        st_nxt.st_und = st_r.st_und & ~wval[SBDAC_BIT_UND];
                    end
                    default:
                    begin
                        // Read-only and reserved words ignore writes
                        st_nxt.pend = st_nxt.pend;
                    end
                endcase
            end
        end

        // Read data selection; reserved bits and words read zero
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            SBDAC_OFS_SAMPLE:
            begin
                rd_val = st_r.sample;
            end
            SBDAC_OFS_CONTROL:
            begin
                rd_val[SBDAC_BIT_EN] = st_r.en;
                rd_val[SBDAC_BIT_SWAP] = st_r.swap;
            end
            SBDAC_OFS_MASK:
            begin
                rd_val[SBDAC_BIT_RDY] = st_r.msk_rdy;
                rd_val[SBDAC_BIT_UND] = st_r.msk_und;
            end
            SBDAC_OFS_STATUS:
            begin
                rd_val[SBDAC_BIT_RDY] = st_r.st_rdy;
                rd_val[SBDAC_BIT_UND] = st_r.st_und;
            end
            default:
            begin
                rd_val = 32'h0000_0000;
            end
        endcase

        // Read address taken; reading status clears both flags
        if (rd_go)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_ok ? rd_val : 32'h0000_0000;
            st_nxt.rresp = rd_ok ? SBDAC_RESP_OKAY : SBDAC_RESP_SLVERR;
            if (rd_ok && (s_axi_araddr == SBDAC_OFS_STATUS))
            begin
                st_nxt.st_rdy = 1'b0;
                st_nxt.st_und = 1'b0;
            end
        end

        // New events override any clear in the same cycle
        st_nxt.st_rdy = st_nxt.st_rdy | rdy_evt;
        st_nxt.st_und = st_nxt.st_und | und_evt;

        // Ready flops follow the next holding state
        st_nxt.awready = !st_nxt.aw_have;
        st_nxt.wready = !st_nxt.w_have;
        st_nxt.arready = !st_nxt.rvalid;

        // Request and interrupt levels, registered for clean outputs
        st_nxt.dma = st_nxt.en && !st_nxt.pend;
        st_nxt.irq = (st_nxt.st_rdy && st_nxt.msk_rdy) ||
                     (st_nxt.st_und && st_nxt.msk_und);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Synchronous reset to constants only
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_r <= '0;
            st_r.awready <= 1'b1;
            st_r.wready <= 1'b1;
            st_r.arready <= 1'b1;
            st_r.sample <= SBDAC_RST_SAMPLE;
            st_r.chan_lo <= SBDAC_RST_CHAN;
            st_r.chan_hi <= SBDAC_RST_CHAN;
            st_r.cv <= SBDAC_CV_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, each straight from the state register
    // ----------------------------------------------------------------
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = st_r.rdata;
    assign chan_lo_sample = st_r.chan_lo;
    assign chan_hi_sample = st_r.chan_hi;
    assign conv_enable = st_r.en;
    assign sample_strobe = st_r.strobe;
    assign dma_req = st_r.dma;
    assign irq = st_r.irq;

endmodule

// ==== hw/sbdac_pkg.sv ====
// Constants, register map and field layout of the stereo bitstream DAC
// register block. Assumes a 32-bit AXI4-Lite bus with byte addresses.
//
// Notes on behaviour
// - Low halfword is first channel sample.
// - High halfword is second channel sample.
// - Swap bit set exchanges halfwords on write.
// - Swap bit clear stores halfwords unchanged.
// - Control bit 31 enables the converter.
// - Mask bit 28 shows underrun interrupt enabled.
// - Mask bit 29 shows ready interrupt enabled.
// - Enable register ones set mask bits.
// - Disable register ones clear mask bits.
// - Clear register ones clear status flags.
// - Underrun flag sticks until status read, reset.
// - Ready flag sticks until status read.
// - Missing sample within 256 converter cycles underruns.
// - Interrupt when any flag and mask set.
// - Request DMA whenever ready for sample.
package sbdac_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] SBDAC_OFS_SAMPLE = 8'h00;
    localparam logic [7:0] SBDAC_OFS_RSVD = 8'h04;
    localparam logic [7:0] SBDAC_OFS_CONTROL = 8'h08;
    localparam logic [7:0] SBDAC_OFS_MASK = 8'h0C;
    localparam logic [7:0] SBDAC_OFS_IEN = 8'h10;
    localparam logic [7:0] SBDAC_OFS_IDIS = 8'h14;
    localparam logic [7:0] SBDAC_OFS_ICLR = 8'h18;
    localparam logic [7:0] SBDAC_OFS_STATUS = 8'h1C;
    localparam logic [7:0] SBDAC_OFS_LAST = 8'h1C;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SBDAC_BIT_EN = 31;
    localparam int SBDAC_BIT_SWAP = 30;
    localparam int SBDAC_BIT_RDY = 29;
    localparam int SBDAC_BIT_UND = 28;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] SBDAC_RST_SAMPLE = 32'h0000_0000;
    localparam logic [15:0] SBDAC_RST_CHAN = 16'h0000;

    // ----------------------------------------------------------------
    // Timing: converter tick divider and sample period in ticks
    // ----------------------------------------------------------------
    localparam logic [7:0] SBDAC_CONV_DIV = 8'h10;
    localparam logic [7:0] SBDAC_TICKS_LAST = 8'hFF;

    // ----------------------------------------------------------------
    // Bus responses
    // ----------------------------------------------------------------
    localparam logic [1:0] SBDAC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SBDAC_RESP_SLVERR = 2'h2;

    // Converter sequencing states
    typedef enum logic [0:0]
    {
        SBDAC_CV_IDLE = 1'b0,
        SBDAC_CV_RUN = 1'b1
    } sbdac_cv_t;

endpackage

// ==== test/sbdac_regs_sva.sv ====
// Checker for the DAC register block: bus handshakes and pacing outputs.
// Assumes it is bound to sbdac_regs and sees only that module's ports.
`timescale 1ns/1ps

module sbdac_regs_sva
    import sbdac_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic nrst, // Reset
    input wire logic [7:0] s_axi_awaddr, // AW addr
    input wire logic s_axi_awvalid, // AW valid
    input wire logic s_axi_awready, // AW ready
    input wire logic [31:0] s_axi_wdata, // W data
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic [7:0] s_axi_araddr, // AR addr
    input wire logic s_axi_arvalid, // AR valid
    input wire logic s_axi_arready, // AR ready
    input wire logic [31:0] s_axi_rdata, // R data
    input wire logic [1:0] s_axi_rresp, // R resp
    input wire logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready, // R ready
    input wire logic [15:0] chan_lo_sample, // Ch 0
    input wire logic [15:0] chan_hi_sample, // Ch 1
    input wire logic conv_enable, // Enable
    input wire logic sample_strobe, // Strobe
    input wire logic dma_req // Request
);
    // ------------------------------------------------------------
    // One clock domain: clocking, reset given once
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Host offers address and data together
    wire logic both_taken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire logic rd_taken = s_axi_arvalid && s_axi_arready;

    a_bvalid_retires: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not retired");
    a_rvalid_retires: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not retired");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open while data pending");
    a_write_latency: assert property (both_taken |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response latency wrong");
    a_read_latency: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read response latency wrong");
    // Past the map: error, zero data
    a_unmapped_err: assert property (rd_taken && s_axi_araddr > SBDAC_OFS_LAST |=>
        s_axi_rresp == SBDAC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_rsvd_zero: assert property (rd_taken && s_axi_araddr == SBDAC_OFS_RSVD |=>
        s_axi_rresp == SBDAC_RESP_OKAY && s_axi_rdata == 32'h0000_0000)
        else $error("reserved offset not zero");
    a_enable_follow: assert property (both_taken && s_axi_awaddr == SBDAC_OFS_CONTROL
        |-> ##2 conv_enable == $past(s_axi_wdata[31], 2))
        else $error("enable output does not follow control");
    // Channels move only on a consumed pair
    a_chan_moves: assert property ($changed(chan_lo_sample) || $changed(chan_hi_sample)
        |-> sample_strobe)
        else $error("channel changed without strobe");
    a_strobe_gap: assert property (sample_strobe |=> !sample_strobe [*8])
        else $error("sample strobe too close");
    a_dma_idle: assert property (!conv_enable [*2] |-> !dma_req)
        else $error("request while disabled");
endmodule

bind sbdac_regs sbdac_regs_sva i_sva (.*);

// ==== test/sbdac_host.sv ====
// Host model: AXI4-Lite master tasks for the register bus.
// Assumes the slave updates its outputs by non-blocking assignment.
`timescale 1ns/1ps

module sbdac_host
(
    input wire logic clk, // Bus clock
    output logic [7:0] awaddr, // Write address
    output logic awvalid, // Write address valid
    input wire logic awready, // Write address ready
    output logic [31:0] wdata, // Write data
    output logic [3:0] wstrb, // Byte strobes, always full word
    output logic wvalid, // Write data valid
    input wire logic wready, // Write data ready
    input wire logic [1:0] bresp, // Write response
    input wire logic bvalid, // Write response valid
    output logic bready, // Write response ready
    output logic [7:0] araddr, // Read address
    output logic arvalid, // Read address valid
    input wire logic arready, // Read address ready
    input wire logic [31:0] rdata, // Read data
    input wire logic [1:0] rresp, // Read response
    input wire logic rvalid, // Read data valid
    output logic rready // Read data ready
);
    // Idle bus from time zero
    initial
    begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} <= '0;
        wstrb <= 4'hF;
    end

    // Word write; response 3 means no answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        resp = 2'h3;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100 && resp === 2'h3; n++)
        begin
            @(posedge clk);
            // Each channel is released only at the edge that took it
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                resp = bresp;
                bready <= 1'b0;
            end
        end
    endtask

    // Word read, data taken at the rvalid edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        resp = 2'h3;
        d = 32'hDEAD_0000;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100 && resp === 2'h3; n++)
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                resp = rresp;
                d = rdata;
                rready <= 1'b0;
            end
        end
    endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the DAC register block through the host model.
// Assumes a 200 MHz clock and a 4096-cycle sample period.
`timescale 1ns/1ps

module testbench;
    import sbdac_pkg::*;

    logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, conv_enable, sample_strobe, dma_req, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] chan_lo, chan_hi;
    int num_errors = 0;
    int tests_run = 0;

    sbdac_regs i_dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chan_lo_sample(chan_lo),
        .chan_hi_sample(chan_hi), .conv_enable(conv_enable), .sample_strobe(sample_strobe),
        .dma_req(dma_req), .irq(irq));
    sbdac_host i_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        i_host.wr(a, d, r);
        if (r === 2'h3) print_verdict();
        check("bresp", {30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] v;
        logic [1:0] r;
        i_host.rd(a, v, r);
        if (r === 2'h3) print_verdict();
        check("rresp", {30'h0, r}, {30'h0, er});
        check("rdata", v, exp);
    endtask

    // Bounded wait for strobe or interrupt; a hang fails
    task automatic wait_for(input bit want_irq);
        for (int n = 0; n < 5000; n++)
        begin
            @(posedge clk);
            if ((want_irq ? irq : sample_strobe) === 1'b1) return;
        end
        num_errors++;
        print_verdict();
    endtask

    // Outputs lag their cause by an edge
    task automatic pins(input logic en, input logic dq, input logic iq);
        repeat (2) @(posedge clk);
        check("conv_enable", {31'h0, conv_enable}, {31'h0, en});
        check("dma_req", {31'h0, dma_req}, {31'h0, dq});
        check("irq", {31'h0, irq}, {31'h0, iq});
    endtask

    task automatic chans(input logic [15:0] lo, input logic [15:0] hi);
        check("chan_lo", {16'h0, chan_lo}, {16'h0, lo});
        check("chan_hi", {16'h0, chan_hi}, {16'h0, hi});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        nrst = 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        // Reset values, reserved and unmapped words
        rd(SBDAC_OFS_SAMPLE, 32'h0, SBDAC_RESP_OKAY);
        rd(SBDAC_OFS_CONTROL, 32'h0, SBDAC_RESP_OKAY);
        rd(SBDAC_OFS_STATUS, 32'h0, SBDAC_RESP_OKAY);
        wr(SBDAC_OFS_RSVD, 32'hFFFF_FFFF, SBDAC_RESP_OKAY);
        rd(SBDAC_OFS_RSVD, 32'h0, SBDAC_RESP_OKAY);
        wr(8'h20, 32'hFFFF_FFFF, SBDAC_RESP_SLVERR);
        rd(8'h20, 32'h0, SBDAC_RESP_SLVERR);
        wr(SBDAC_OFS_CONTROL, 32'h3FFF_FFFF, SBDAC_RESP_OKAY);
        rd(SBDAC_OFS_CONTROL, 32'h0, SBDAC_RESP_OKAY);
        // Mask is set, cleared and read only
        wr(SBDAC_OFS_MASK, 32'h3000_0000, SBDAC_RESP_OKAY);
        rd(SBDAC_OFS_MASK, 32'h0, SBDAC_RESP_OKAY);
        wr(SBDAC_OFS_IEN, 32'h3000_0000, SBDAC_RESP_OKAY);
        rd(SBDAC_OFS_MASK, 32'h3000_0000, SBDAC_RESP_OKAY);
        wr(SBDAC_OFS_IDIS, 32'h1000_0000, SBDAC_RESP_OKAY);
        wr(SBDAC_OFS_IEN, 32'h0, SBDAC_RESP_OKAY);
        rd(SBDAC_OFS_MASK, 32'h2000_0000, SBDAC_RESP_OKAY);
        // Enable while empty: request and ready flag
        wr(SBDAC_OFS_CONTROL, 32'h8000_0000, SBDAC_RESP_OKAY);
        pins(1'b1, 1'b1, 1'b1);
        wr(SBDAC_OFS_SAMPLE, 32'h2222_1111, SBDAC_RESP_OKAY);
        pins(1'b1, 1'b0, 1'b1);
        rd(SBDAC_OFS_SAMPLE, 32'h2222_1111, SBDAC_RESP_OKAY);
        rd(SBDAC_OFS_STATUS, 32'h2000_0000, SBDAC_RESP_OKAY);
        pins(1'b1, 1'b0, 1'b0);
        rd(SBDAC_OFS_STATUS, 32'h0, SBDAC_RESP_OKAY);
        wait_for(1'b0);
        chans(16'h1111, 16'h2222);
        pins(1'b1, 1'b1, 1'b1);
        rd(SBDAC_OFS_STATUS, 32'h2000_0000, SBDAC_RESP_OKAY);
        // Swapped pair
        wr(SBDAC_OFS_CONTROL, 32'hC000_0000, SBDAC_RESP_OKAY);
        wr(SBDAC_OFS_SAMPLE, 32'h4444_3333, SBDAC_RESP_OKAY);
        rd(SBDAC_OFS_SAMPLE, 32'h3333_4444, SBDAC_RESP_OKAY);
        wait_for(1'b0);
        chans(16'h4444, 16'h3333);
        rd(SBDAC_OFS_STATUS, 32'h2000_0000, SBDAC_RESP_OKAY);
        // No sample offered: underrun, then clear
        wr(SBDAC_OFS_IEN, 32'h1000_0000, SBDAC_RESP_OKAY);
        wr(SBDAC_OFS_IDIS, 32'h2000_0000, SBDAC_RESP_OKAY);
        rd(SBDAC_OFS_MASK, 32'h1000_0000, SBDAC_RESP_OKAY);
        wait_for(1'b1);
        chans(16'h4444, 16'h3333);
        rd(SBDAC_OFS_STATUS, 32'h1000_0000, SBDAC_RESP_OKAY);
        pins(1'b1, 1'b1, 1'b0);
        wait_for(1'b1);
        wr(SBDAC_OFS_ICLR, 32'h1000_0000, SBDAC_RESP_OKAY);
        pins(1'b1, 1'b1, 1'b0);
        rd(SBDAC_OFS_STATUS, 32'h0, SBDAC_RESP_OKAY);
        // Disable drops enable and request
        wr(SBDAC_OFS_CONTROL, 32'h0, SBDAC_RESP_OKAY);
        pins(1'b0, 1'b0, 1'b0);
        print_verdict();
    end
endmodule
